/* hdl/mr_pkg.sv */
// Package: encodings, widths and reset values of the move and return instruction executor
package mr_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FILE_ADDR_W = 7;
  localparam int PC_W = 13;

  // Opcode patterns, compared under the masks below; the return-from-interrupt code is matched against the whole word
  localparam logic [13:0] STORE_ACC_MASK = 14'h3f80;
  localparam logic [13:0] STORE_ACC_CODE = 14'h0080;
  localparam logic [13:0] LOAD_LIT_MASK = 14'h3c00;
  localparam logic [13:0] LOAD_LIT_CODE = 14'h3000;
  localparam logic [13:0] RET_LIT_MASK = 14'h3c00;
  localparam logic [13:0] RET_LIT_CODE = 14'h3400;
  localparam logic [13:0] NOP_MASK = 14'h3f9f;
  localparam logic [13:0] NOP_CODE = 14'h0000;
  localparam logic [13:0] RET_INT_CODE = 14'h0009;

  // Field positions inside the instruction word
  localparam int FILE_ADDR_LSB = 0;
  localparam int LITERAL_LSB = 0;

  // Global interrupt enable position in the interrupt control register
  localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 7;

  // Cycle counts per instruction
  localparam int SINGLE_CYCLES = 1;
  localparam int RETURN_CYCLES = 2;

  // Values after reset
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [6:0] FILE_ADDR_RESET = 7'h00;

  typedef enum logic [2:0] {
    MR_OP_NONE,
    MR_OP_STORE_ACC,
    MR_OP_LOAD_LIT,
    MR_OP_NOP,
    MR_OP_RET_INT,
    MR_OP_RET_LIT
  } mr_op_type;

  typedef enum logic {
    MR_ST_RUN,
    MR_ST_FLUSH
  } mr_state_type;
endpackage

/* hdl/mr_exec.sv */
// Executor for store, load-literal, no-operation and return instructions of an 8-bit core
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// RULE1 - Store accumulator copies working register into file register at 7-bit address; one cycle, flags kept.
// RULE2 - Load literal puts 8-bit immediate into working register in one cycle, flags kept.
// RULE3 - Program image encodes don't-care bits of load literal as zeros.
// RULE4 - Return from interrupt pops stack, loads top of stack into PC; two cycles, flags kept.
// RULE5 - Return from interrupt also sets global interrupt enable, bit 7 of interrupt control.
// RULE6 - Return with literal loads immediate into working register, pops stack into PC; two cycles.
// RULE7 - No-operation changes nothing except advancing the program counter, in one cycle.
module mr_exec #(
  parameter int INSTR_W = mr_pkg::INSTR_W,
  parameter int PC_W = mr_pkg::PC_W
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  output logic instr_ready,
  input wire logic [PC_W-1:0] top_of_stack,
  output logic [mr_pkg::DATA_W-1:0] accumulator,
  output logic file_write,
  output logic [mr_pkg::FILE_ADDR_W-1:0] file_addr,
  output logic [mr_pkg::DATA_W-1:0] file_data,
  output logic stack_pop,
  output logic pc_advance,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  output logic global_interrupt_enable_set,
  output logic status_write,
  output logic illegal_instr
);

  // Refuse shapes the decoder and the fixed flush slot cannot serve
  initial begin
    if (INSTR_W != mr_pkg::INSTR_W) begin
      $error("mr_exec: instruction width must match the opcode masks");
    end
    if (PC_W < 1 || PC_W > 16) begin
      $error("mr_exec: program counter width out of range");
    end
    if (mr_pkg::LITERAL_LSB + mr_pkg::DATA_W > INSTR_W) begin
      $error("mr_exec: literal field lies outside the instruction word");
    end
    if (mr_pkg::FILE_ADDR_LSB + mr_pkg::FILE_ADDR_W > INSTR_W) begin
      $error("mr_exec: file address field lies outside the instruction word");
    end
    if (mr_pkg::GLOBAL_INTERRUPT_ENABLE_BIT >= mr_pkg::DATA_W) begin
      $error("mr_exec: interrupt enable bit lies outside the control register");
    end
    if (mr_pkg::SINGLE_CYCLES != 1 || mr_pkg::RETURN_CYCLES != 2) begin
      $error("mr_exec: only one flush slot per return is built");
    end
  end

  mr_pkg::mr_state_type state;
  mr_pkg::mr_state_type next_state;
  mr_pkg::mr_op_type op;
  logic take;
  logic [mr_pkg::DATA_W-1:0] literal;
  logic [mr_pkg::FILE_ADDR_W-1:0] operand_addr;
  logic is_store;
  logic is_load_lit;
  logic is_ret_lit;
  logic is_ret_int;
  logic is_nop;
  logic is_unknown;
  logic is_return;
  logic is_single;

  assign literal = instr_word[mr_pkg::LITERAL_LSB +: mr_pkg::DATA_W];
  assign operand_addr = instr_word[mr_pkg::FILE_ADDR_LSB +: mr_pkg::FILE_ADDR_W];

  // Decode; literal forms ignore the don't-care bits, trusting the image to zero them [RULE3]
  always_comb begin
    if ((instr_word & mr_pkg::STORE_ACC_MASK) == mr_pkg::STORE_ACC_CODE) begin
      op = mr_pkg::MR_OP_STORE_ACC;
    end else if ((instr_word & mr_pkg::LOAD_LIT_MASK) == mr_pkg::LOAD_LIT_CODE) begin
      op = mr_pkg::MR_OP_LOAD_LIT;
    end else if ((instr_word & mr_pkg::RET_LIT_MASK) == mr_pkg::RET_LIT_CODE) begin
      op = mr_pkg::MR_OP_RET_LIT;
    end else if (instr_word == mr_pkg::RET_INT_CODE) begin
      op = mr_pkg::MR_OP_RET_INT;
    end else if ((instr_word & mr_pkg::NOP_MASK) == mr_pkg::NOP_CODE) begin
      op = mr_pkg::MR_OP_NOP;
    end else begin
      op = mr_pkg::MR_OP_NONE;
    end
  end

  // The second cycle of a return is a flush slot: fetch must not present a new word
  assign instr_ready = (state == mr_pkg::MR_ST_RUN);
  assign take = instr_valid && instr_ready;

  // One view per taken kind, so each output below except the working register reads one term
  assign is_store = take && (op == mr_pkg::MR_OP_STORE_ACC);
  assign is_load_lit = take && (op == mr_pkg::MR_OP_LOAD_LIT);
  assign is_ret_lit = take && (op == mr_pkg::MR_OP_RET_LIT);
  assign is_ret_int = take && (op == mr_pkg::MR_OP_RET_INT);
  assign is_nop = take && (op == mr_pkg::MR_OP_NOP);
  assign is_unknown = take && (op == mr_pkg::MR_OP_NONE);
  assign is_return = is_ret_int || is_ret_lit;
  assign is_single = is_store || is_load_lit || is_nop;

  always_comb begin
    next_state = state;
    unique case (state)
      mr_pkg::MR_ST_RUN: begin
        if (is_return) begin
          next_state = mr_pkg::MR_ST_FLUSH; // [RULE4] [RULE6]
        end
      end
      mr_pkg::MR_ST_FLUSH: begin
        next_state = mr_pkg::MR_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= mr_pkg::MR_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Working register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      accumulator <= mr_pkg::ACC_RESET;
    end else if (is_load_lit || is_ret_lit) begin
      accumulator <= literal; // [RULE2] [RULE6]
    end
  end

  // Write strobe lasts one cycle; address and data hold after it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      file_write <= 1'b0;
    end else begin
      file_write <= is_store; // [RULE1]
    end
  end

  // Data is the working register as it stood before this cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      file_addr <= mr_pkg::FILE_ADDR_RESET;
      file_data <= mr_pkg::ACC_RESET;
    end else if (is_store) begin
      file_addr <= operand_addr; // [RULE1]
      file_data <= accumulator; // [RULE1]
    end
  end

  // Single-word, single-cycle instructions just step the counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pc_advance <= 1'b0;
    end else begin
      pc_advance <= is_single; // [RULE1] [RULE2] [RULE7]
    end
  end

  // One pop per return; the flush slot keeps a second one out
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stack_pop <= 1'b0;
    end else begin
      stack_pop <= is_return; // [RULE4] [RULE6]
    end
  end

  // Load strobe rides with the pop so the core takes pc_value then
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pc_load <= 1'b0;
    end else begin
      pc_load <= is_return; // [RULE4] [RULE6]
    end
  end

  // Sampled at take, before the pop disturbs the stack output
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pc_value <= PC_W'(mr_pkg::PC_RESET);
    end else if (is_return) begin
      pc_value <= top_of_stack; // [RULE4] [RULE6]
    end
  end

  // Set pulse only; the enable bit itself lives in the interrupt control register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      global_interrupt_enable_set <= 1'b0;
    end else begin
      global_interrupt_enable_set <= is_ret_int; // [RULE5]
    end
  end

  // None of these instructions touches the status flags
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status_write <= 1'b0;
    end else begin
      status_write <= 1'b0; // [RULE1] [RULE2] [RULE4] [RULE6] [RULE7]
    end
  end

  // Unknown words only raise this; they neither step nor load the counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      illegal_instr <= 1'b0;
    end else begin
      illegal_instr <= is_unknown;
    end
  end

endmodule
`default_nettype wire

/* bench/mr_exec_sva.sv */
// Checker of the move and return executor outputs
`timescale 1ns/100ps
`default_nettype none
module mr_exec_sva (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic file_write,
  input wire logic stack_pop,
  input wire logic pc_advance,
  input wire logic pc_load,
  input wire logic global_interrupt_enable_set,
  input wire logic status_write,
  input wire logic [13:0] instr_word,
  input wire logic [12:0] top_of_stack,
  input wire logic [12:0] pc_value,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] file_data,
  input wire logic [6:0] file_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire tk = instr_valid && instr_ready;
  wire ri = tk && instr_word == 14'h0009;
  store_copy_a: assert property (tk && (instr_word & 14'h3f80) == 14'h0080 |=>
    file_write && pc_advance && file_addr == $past(instr_word[6:0]) && file_data == $past(accumulator)) else $error("store");
  load_lit_a: assert property (tk && instr_word[13:10] == 4'hc |=>
    accumulator == $past(instr_word[7:0]) && pc_advance && !file_write) else $error("load literal");
  ret_pop_a: assert property (ri |=> stack_pop && pc_load && global_interrupt_enable_set && !instr_ready
    && pc_value == $past(top_of_stack) ##1 instr_ready && !stack_pop) else $error("return interrupt");
  gie_cause_a: assert property (global_interrupt_enable_set |-> $past(ri)) else $error("stray enable");
  ret_lit_a: assert property (tk && instr_word[13:10] == 4'hd |=>
    accumulator == $past(instr_word[7:0]) && stack_pop && pc_load && !global_interrupt_enable_set) else $error("retlit");
  flags_kept_a: assert property (!status_write) else $error("flag write");
  nop_quiet_a: assert property (tk && (instr_word & 14'h3f9f) == 14'h0000 |=>
    pc_advance && !file_write && !stack_pop && !pc_load && $stable(accumulator)) else $error("nop");
  pop_pair_a: assert property (stack_pop |-> pc_load && !pc_advance ##1 !stack_pop) else $error("pop");
  cover property (ri);
  cover property (file_write);
  cover property (stack_pop && !global_interrupt_enable_set);
endmodule
bind mr_exec mr_exec_sva mr_exec_sva_i (.*);
`default_nettype wire

/* bench/mr_fetch.sv */
// Instruction fetch model that presents a word until it is taken
`timescale 1ns/100ps
`default_nettype none
module mr_fetch (
  input wire logic mclk,
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [13:0] instr_word
);
  initial begin
    instr_valid = 1'b0;
    instr_word = 14'h0000;
  end
  // Ready is judged at the falling edge, where it has settled
  task automatic issue(input logic [13:0] w);
    @(negedge mclk);
    instr_valid = 1'b1;
    instr_word = w;
    while (instr_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
  endtask
  // Released bus shows no stale word
  task automatic idle();
    @(negedge mclk);
    instr_valid = 1'b0;
    instr_word = ~instr_word;
  endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
// Bench for the move and return executor
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct {logic [13:0] w; logic [7:0] acc; logic [7:0] fl;} mr_row_type;
  logic mclk, arst_n, instr_valid, instr_ready, fw, pop, adv, ld, global_interrupt_enable, sw, ill;
  logic [13:0] instr_word;
  logic [7:0] acc, fd;
  logic [6:0] fa;
  logic [12:0] pcv;
  int error_cnt = 0;
  int n_checks = 0;
  // Flags: status, ready, enable, illegal, write, pop, advance, load
  mr_row_type rows[9] = '{'{14'h30a5, 8'ha5, 8'h42}, '{14'h00ff, 8'ha5, 8'h4a}, '{14'h0000, 8'ha5, 8'h42},
    '{14'h0060, 8'ha5, 8'h42}, '{14'h3000, 8'h00, 8'h42}, '{14'h34ff, 8'hff, 8'h05},
    '{14'h0009, 8'hff, 8'h25}, '{14'h0080, 8'hff, 8'h4a}, '{14'h3fff, 8'hff, 8'h50}};
  mr_fetch mr_fetch_i (.mclk(mclk), .instr_ready(instr_ready), .instr_valid(instr_valid), .instr_word(instr_word));
  mr_exec mr_exec_i (.mclk(mclk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .top_of_stack(~instr_word[12:0]), .accumulator(acc), .file_write(fw),
    .file_addr(fa), .file_data(fd), .stack_pop(pop), .pc_advance(adv), .pc_load(ld), .pc_value(pcv),
    .global_interrupt_enable_set(global_interrupt_enable), .status_write(sw), .illegal_instr(ill));
  function automatic logic [15:0] st();
    return {acc, sw, instr_ready, global_interrupt_enable, ill, fw, pop, adv, ld};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #5000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    arst_n = 1'b0;
    repeat (2) @(negedge mclk);
    cmp(st(), 16'h0040);
    arst_n = 1'b1;
    foreach (rows[i]) begin
      mr_fetch_i.issue(rows[i].w);
      #1;
      cmp(st(), {rows[i].acc, rows[i].fl});
      if (rows[i].fl[0]) cmp({3'h0, pcv}, {3'h0, ~rows[i].w[12:0]});
      if (rows[i].fl[3]) cmp({1'h0, fa, fd}, {1'h0, rows[i].w[6:0], rows[i].acc});
    end
    $display("test rows done");
    mr_fetch_i.issue(14'h3012);
    #1;
    cmp(st(), 16'h1242);
    mr_fetch_i.idle();
    arst_n = 1'b0;
    #1;
    cmp(st(), 16'h0040);
    @(negedge mclk);
    arst_n = 1'b1;
    mr_fetch_i.issue(14'h0009);
    #1;
    cmp(st(), 16'h0025);
    cmp({3'h0, pcv}, 16'h1ff6);
    $display("test reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
